// ===== rtl/ppf_pkg.sv
package ppf_pkg;
  // priority 0 pause quanta defaults
  localparam logic [15:0] PAUSE_QUANTA_RST   = 16'hffff;
  localparam logic [15:0] REFRESH_QUANTA_RST = 16'hff00;
  localparam logic [15:0] XON_QUANTA         = 16'h0000;
  // one pause quantum is 512 bit times; 64 bits per cycle at 10G
  localparam int          BITS_PER_QUANTUM   = 512;
  localparam int          BITS_PER_CYCLE     = 64;
  localparam int          CYC_PER_QUANTUM    = BITS_PER_QUANTUM / BITS_PER_CYCLE;
  localparam int          QTICK_W            = 4;
  // frame kinds sent to the framer
  typedef enum logic [1:0] {
    PPF_FRM_XOFF = 2'h1,
    PPF_FRM_XON  = 2'h2
  } ppf_frm_t;
endpackage

// ===== rtl/ppf_rx_if.sv
`timescale 1ns/100ps
// carries a decoded received pause frame into the receive counter
interface ppf_rx_if;
  logic        frame_valid;
  logic [15:0] quanta;
  logic        qtick;
  logic        pause;
  modport src (output frame_valid, output quanta, output qtick, input pause);
  modport cnt (input frame_valid, input quanta, input qtick, output pause);
endinterface

// ===== rtl/ppf_rx_counter.sv
`timescale 1ns/100ps
// receive side quanta down-counter for priority 0
module ppf_rx_counter (
  input  wire logic clk_sys,
  input  wire logic rstn,
  ppf_rx_if.cnt     rx
);
  logic [15:0] count_q;
  logic [15:0] count_d;

  // a zero-quanta frame loads zero and drops the pause at once
  always_comb begin
    count_d = count_q;
    if (rx.frame_valid) begin
      count_d = rx.quanta;
    end else if (rx.qtick && count_q != 16'h0000) begin
      count_d = count_q - 16'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      count_q <= 16'h0000;
    end else begin
      count_q <= count_d;
    end
  end

  // indication stays high while the counter is non-zero
  assign rx.pause = (count_q != 16'h0000);
endmodule // ppf_rx_counter

// ===== rtl/ppf_flow_ctrl.sv
`timescale 1ns/100ps
// Operation
// - xoff frame carries programmed quanta, default ffff
// - resend pause each refresh count while requested
// - auto xon sends zero-quanta frame on drop of a request held over one cycle
// - zero-quanta frame drops pause indication immediately
// - auto xon off: no frame on drop
// - indication high on xoff; partner halts fifo
// - request held over one cycle is refreshed xoff
// - indication high while quanta counter non-zero
module ppf_flow_ctrl (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        tx_prio0_pause_request,
  input  wire logic        auto_xon_en,
  input  wire logic [15:0] pause_quanta,
  input  wire logic [15:0] refresh_quanta,
  input  wire logic        rx_frame_valid,
  input  wire logic [15:0] rx_frame_quanta,
  output logic             tx_frame_valid,
  input  wire logic        tx_frame_ready,
  output logic [1:0]       tx_frame_kind,
  output logic [15:0]      tx_frame_quanta,
  output logic             rx_prio0_pause_indication
);
  ////////////////////////////////////////////////////////////////////
  // quantum tick divider: one slot per 512 bit times; the length is
  // fixed for a 64-bit datapath, a narrower one needs another count
  // both the refresh count and the receive counter age on this tick
  logic [ppf_pkg::QTICK_W-1:0] div_q;
  logic [ppf_pkg::QTICK_W-1:0] div_d;
  logic                        qtick;

  always_comb begin
    qtick = (div_q == ppf_pkg::QTICK_W'(ppf_pkg::CYC_PER_QUANTUM - 1));
    div_d = qtick ? '0 : div_q + 1'b1;
  end

  // divider free-runs from reset, so the first quantum is a whole one
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      div_q <= '0;
    end else begin
      div_q <= div_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // transmit request tracking: how long the client has held the request
  typedef enum logic [2:0] {
    PPF_REQ_IDLE  = 3'b001,  // request low
    PPF_REQ_FIRST = 3'b010,  // first cycle high
    PPF_REQ_HELD  = 3'b100   // high for more than one cycle
  } ppf_req_st_t;

  ppf_req_st_t req_st_q;
  ppf_req_st_t req_st_d;
  logic        req_rise;   // request went high this cycle
  logic        req_held;   // request still high after its first two cycles
  logic        req_drop;   // held request released this cycle

  // a single-cycle pulse never reaches held, so it gets one xoff and
  // neither refresh nor xon; only a held request is a standing xoff
  // that the block keeps alive until the client lets go of it
  always_comb begin
    req_st_d = req_st_q;
    req_rise = 1'b0;
    req_held = 1'b0;
    req_drop = 1'b0;
    unique case (req_st_q)
      PPF_REQ_IDLE: begin
        if (tx_prio0_pause_request) begin
          req_st_d = PPF_REQ_FIRST;
          req_rise = 1'b1;
        end
      end
      PPF_REQ_FIRST: begin
        req_st_d = tx_prio0_pause_request ? PPF_REQ_HELD : PPF_REQ_IDLE;
      end
      PPF_REQ_HELD: begin
        req_held = tx_prio0_pause_request;
        req_drop = !tx_prio0_pause_request;
        req_st_d = tx_prio0_pause_request ? PPF_REQ_HELD : PPF_REQ_IDLE;
      end
      default: begin
        req_st_d = PPF_REQ_IDLE;
      end
    endcase
  end

  // request comes from logic on this clock, so no synchroniser
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      req_st_q <= PPF_REQ_IDLE;
    end else begin
      req_st_q <= req_st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // frame scheduling: pending xoff and xon, refresh quanta count
  logic [15:0] qcount_q;    // quanta since the last frame went out
  logic [15:0] qcount_d;
  logic        pend_xoff_q;
  logic        pend_xoff_d;
  logic        pend_xon_q;
  logic        pend_xon_d;
  logic        send;        // framer takes the offered frame
  logic        slot_free;   // output register can take a new frame
  logic        load;        // a pending frame moves into the output

  // a pending frame is retired when it is loaded, not when it is sent;
  // a flag still set at load time would be offered a second time
  always_comb begin
    send        = tx_frame_valid && tx_frame_ready;
    slot_free   = !tx_frame_valid || tx_frame_ready;
    load        = slot_free && (pend_xon_q || pend_xoff_q);
    pend_xoff_d = pend_xoff_q;
    pend_xon_d  = pend_xon_q;
    qcount_d    = qcount_q;
    if (load) begin
      pend_xoff_d = 1'b0;
      pend_xon_d  = 1'b0;
    end
    // any frame on the wire restarts the refresh count
    if (send) begin
      qcount_d = 16'h0000;
    end else if (qtick && qcount_q != 16'hffff) begin
      qcount_d = qcount_q + 16'h0001;
    end
    // new rising request: send xoff
    if (req_rise) begin
      pend_xoff_d = 1'b1;
    end
    // refresh while held; waits while a frame is queued or offered,
    // since that frame restarts the count when it goes out
    if (req_held && !pend_xoff_q && !tx_frame_valid
        && qcount_q >= refresh_quanta) begin
      pend_xoff_d = 1'b1;
    end
    // release of a held request: xon only when enabled
    if (req_drop) begin
      pend_xoff_d = 1'b0;
      pend_xon_d  = auto_xon_en;
    end
    // a request that comes back cancels a waiting xon
    if (tx_prio0_pause_request) begin
      pend_xon_d = 1'b0;
    end
  end

  // scheduling state, registered only
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      qcount_q    <= 16'h0000;
      pend_xoff_q <= 1'b0;
      pend_xon_q  <= 1'b0;
    end else begin
      qcount_q    <= qcount_d;
      pend_xoff_q <= pend_xoff_d;
      pend_xon_q  <= pend_xon_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // frame request outputs, registered data
  logic [1:0]  kind_d;
  logic [15:0] quanta_d;
  logic        valid_d;

  // an offer stands until the framer takes it; xon beats a pending
  // xoff because it ends the remote pause sooner
  always_comb begin
    valid_d  = tx_frame_valid && !tx_frame_ready;
    kind_d   = tx_frame_kind;
    quanta_d = tx_frame_quanta;
    if (!valid_d) begin
      if (pend_xon_q) begin
        valid_d  = 1'b1;
        kind_d   = ppf_pkg::PPF_FRM_XON;
        quanta_d = ppf_pkg::XON_QUANTA;
      end else if (pend_xoff_q) begin
        valid_d  = 1'b1;
        kind_d   = ppf_pkg::PPF_FRM_XOFF;
        quanta_d = pause_quanta;
      end
    end
  end

  // frame fields come straight from flops, stable while offered
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      tx_frame_valid  <= 1'b0;
      tx_frame_kind   <= 2'h0;
      tx_frame_quanta <= ppf_pkg::PAUSE_QUANTA_RST;
    end else begin
      tx_frame_valid  <= valid_d;
      tx_frame_kind   <= kind_d;
      tx_frame_quanta <= quanta_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // receive pause indication
  // a zero-quanta frame clears the counter, so the remote side resumes
  // at once instead of waiting out the earlier pause
  ppf_rx_if rxi ();
  assign rxi.frame_valid = rx_frame_valid;
  assign rxi.quanta      = rx_frame_quanta;
  assign rxi.qtick       = qtick;

  ppf_rx_counter u_rx_counter (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .rx      (rxi.cnt)
  );

  assign rx_prio0_pause_indication = rxi.pause;
endmodule // ppf_flow_ctrl

// ===== tb/ppf_framer_model.sv
`timescale 1ns/100ps
// framer stand-in: takes a frame at once unless the bench stalls it
module ppf_framer_model (
  input  wire logic clk_sys,
  input  wire logic tx_frame_valid,
  input  wire logic stall,
  output logic      tx_frame_ready
);
  // ready only with an offer, so a held stall really blocks the frame
  assign tx_frame_ready = tx_frame_valid && !stall;
endmodule // ppf_framer_model

// ===== tb/ppf_flow_ctrl_props.sv
`timescale 1ns/100ps
// port checks beside the flow control block
module ppf_flow_ctrl_props (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        tx_prio0_pause_request,
  input wire logic        auto_xon_en,
  input wire logic [15:0] pause_quanta,
  input wire logic        rx_frame_valid,
  input wire logic [15:0] rx_frame_quanta,
  input wire logic        tx_frame_valid,
  input wire logic        tx_frame_ready,
  input wire logic [1:0]  tx_frame_kind,
  input wire logic [15:0] tx_frame_quanta,
  input wire logic        rx_prio0_pause_indication
);
  // short aliases
  wire req = tx_prio0_pause_request;
  wire ind = rx_prio0_pause_indication;
  wire vld = tx_frame_valid;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  ////////////////////////
  // offers land two cycles after the request edge
  sequence s_xoff;
    ##2 vld && tx_frame_kind == 2'h1;
  endsequence
  sequence s_xon;
    ##2 vld && tx_frame_kind == 2'h2 && tx_frame_quanta == 16'h0000;
  endsequence
  a_rise_xoff: assert property ($rose(req) |-> s_xoff)
    else $error("xoff late");
  a_drop_xon: assert property
    ($fell(req) && $past(req, 2) && auto_xon_en |-> s_xon)
    else $error("xon late");
  a_xoff_quanta: assert property
    (vld && tx_frame_kind == 2'h1 |-> tx_frame_quanta == pause_quanta)
    else $error("xoff quanta");
  a_xon_off: assert property
    (!auto_xon_en |-> !(vld && tx_frame_kind == 2'h2))
    else $error("xon sent");
  a_offer_held: assert property
    (vld && !tx_frame_ready |=> vld && $stable(tx_frame_quanta))
    else $error("offer dropped");
  a_ind_set: assert property
    (rx_frame_valid && rx_frame_quanta != 16'h0000 |=> ind)
    else $error("no indication");
  a_zero_drop: assert property
    (rx_frame_valid && rx_frame_quanta == 16'h0000 |=> !ind)
    else $error("indication kept");
  a_ind_holds: assert property
    (rx_frame_valid && rx_frame_quanta > 16'h0001 |=> ind [*8])
    else $error("indication short");
  a_kind_legal: assert property
    (vld |-> tx_frame_kind == 2'h1 || tx_frame_kind == 2'h2)
    else $error("bad frame kind");
endmodule // ppf_flow_ctrl_props
bind ppf_flow_ctrl ppf_flow_ctrl_props ppf_flow_ctrl_props_i (
  .clk_sys                   (clk_sys),
  .rstn                      (rstn),
  .tx_prio0_pause_request    (tx_prio0_pause_request),
  .auto_xon_en               (auto_xon_en),
  .pause_quanta              (pause_quanta),
  .rx_frame_valid            (rx_frame_valid),
  .rx_frame_quanta           (rx_frame_quanta),
  .tx_frame_valid            (tx_frame_valid),
  .tx_frame_ready            (tx_frame_ready),
  .tx_frame_kind             (tx_frame_kind),
  .tx_frame_quanta           (tx_frame_quanta),
  .rx_prio0_pause_indication (rx_prio0_pause_indication)
);

// ===== tb/ppf_flow_ctrl_bench.sv
`timescale 1ns/100ps
module ppf_flow_ctrl_bench;
  logic        clk_sys, rstn, tx_prio0_pause_request, auto_xon_en, stall;
  logic        rx_frame_valid, tx_frame_valid, tx_frame_ready;
  logic        rx_prio0_pause_indication;
  logic [15:0] pause_quanta, refresh_quanta, rx_frame_quanta, tx_frame_quanta;
  logic [1:0]  tx_frame_kind;
  int          fails, tests_run, cyc, waited, gap;
  bit          got;
  localparam int FIFO_DEPTH = 64; // client fifo depth, a multiple of 8
  ppf_flow_ctrl ppf_flow_ctrl_i (
    .clk_sys                   (clk_sys),
    .rstn                      (rstn),
    .tx_prio0_pause_request    (tx_prio0_pause_request),
    .auto_xon_en               (auto_xon_en),
    .pause_quanta              (pause_quanta),
    .refresh_quanta            (refresh_quanta),
    .rx_frame_valid            (rx_frame_valid),
    .rx_frame_quanta           (rx_frame_quanta),
    .tx_frame_valid            (tx_frame_valid),
    .tx_frame_ready            (tx_frame_ready),
    .tx_frame_kind             (tx_frame_kind),
    .tx_frame_quanta           (tx_frame_quanta),
    .rx_prio0_pause_indication (rx_prio0_pause_indication)
  );
  ppf_framer_model ppf_framer_model_i (
    .clk_sys        (clk_sys),
    .tx_frame_valid (tx_frame_valid),
    .stall          (stall),
    .tx_frame_ready (tx_frame_ready)
  );
  // clock and a hang guard far beyond the few hundred cycles used
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      results();
    end
  end
  ////////////////////////
  task results;
    $display("fails %0d tests_run %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input bit ok);
    tests_run++;
    if (!ok) begin
      fails++;
      $display("MISMATCH %0t check %0d", $time, tests_run);
    end
  endtask
  // inputs move 1 ns after the edge
  task tick(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      #1;
    end
  endtask
  // waits for an offer and counts the cycles it took
  task wfr;
    waited = 0;
    while (waited < 60 && tx_frame_valid !== 1'b1) begin
      tick(1);
      waited++;
    end
    got = tx_frame_valid === 1'b1;
  endtask
  task quiet;
    got = 1'b1;
    repeat (60) begin
      tick(1);
      if (tx_frame_valid !== 1'b0) got = 1'b0;
    end
  endtask
  task rxf(input logic [15:0] q);
    rx_frame_valid = 1'b1;
    rx_frame_quanta = q;
    tick(1);
    rx_frame_valid = 1'b0;
  endtask
  // client side of the fifo: raise above 7/8, drop below 3/4, else hold
  task fill(input int level);
    if (level * 8 > FIFO_DEPTH * 7) begin
      tx_prio0_pause_request = 1'b1;
    end else if (level * 4 < FIFO_DEPTH * 3) begin
      tx_prio0_pause_request = 1'b0;
    end // between the thresholds the request keeps its state
  endtask
  // main sequence; refresh shortened to four quanta
  initial begin
    {rstn, tx_prio0_pause_request, rx_frame_valid, stall} = 4'h0;
    {auto_xon_en, pause_quanta, refresh_quanta} = {1'b1, 16'hffff, 16'h0004};
    rx_frame_quanta = 16'h0000;
    gap = int'(refresh_quanta) * ppf_pkg::CYC_PER_QUANTUM;
    tick(2);
    rstn = 1'b1;
    fill(60);
    wfr();
    chk(got && waited == 2 && tx_frame_kind === 2'h1
        && tx_frame_quanta === 16'hffff);
    fill(52); // between thresholds the request stays up
    tick(1);
    wfr();
    chk(got && tx_frame_kind === 2'h1
        && waited >= gap - ppf_pkg::CYC_PER_QUANTUM
        && waited <= gap + ppf_pkg::CYC_PER_QUANTUM);
    tick(2);
    fill(40);
    wfr();
    chk(got && waited == 2 && tx_frame_kind === 2'h2
        && tx_frame_quanta === 16'h0000);
    tick(2);
    tx_prio0_pause_request = 1'b1;
    tick(1);
    tx_prio0_pause_request = 1'b0;
    wfr();
    chk(got && tx_frame_kind === 2'h1);
    quiet();
    chk(got);
    {auto_xon_en, stall, tx_prio0_pause_request} = 3'h3;
    tick(6);
    stall = 1'b0;
    tick(4);
    tx_prio0_pause_request = 1'b0;
    quiet();
    chk(got);
    rxf(16'h0003);
    chk(rx_prio0_pause_indication === 1'b1);
    tick(12);
    chk(rx_prio0_pause_indication === 1'b1);
    rxf(16'h0000);
    chk(rx_prio0_pause_indication === 1'b0);
    rxf(16'h0001);
    tick(20);
    chk(rx_prio0_pause_indication === 1'b0);
    results();
  end
endmodule // ppf_flow_ctrl_bench
